// >>> clk_cfg_pkg.sv
// constants and carrier types for the input clock configuration bank
// assumes a wishbone classic slave with 8-bit data and byte addresses
package clk_cfg_pkg;
  localparam logic [7:0] ADDR_STATUS3   = 8'h0F;
  localparam logic [7:0] ADDR_IRQ_EN3   = 8'h12;
  localparam logic [7:0] ADDR_IN1       = 8'h14;
  localparam logic [7:0] ADDR_IN2       = 8'h15;
  localparam logic [7:0] ADDR_IN3       = 8'h16;
  localparam logic [7:0] ADDR_IN4       = 8'h17;
  localparam logic [7:0] ADDR_HF_DIV    = 8'h18;
  localparam logic [7:0] ADDR_IN5       = 8'h19;
  localparam logic [7:0] ADDR_IN6       = 8'h1A;
  localparam logic [7:0] ADDR_IN7       = 8'h1B;
  localparam logic [7:0] ADDR_GLOBAL    = 8'h09;

  localparam logic [7:0] IRQ_EN_MASK    = 8'hDF;
  localparam logic [7:0] IN12_MASK      = 8'h7F;
  localparam logic [7:0] HF_DIV_MASK    = 8'hC3;
  localparam logic [7:0] GLOBAL_MASK    = 8'h04;
  localparam logic [7:0] STATUS_MASK    = 8'hDF;

  localparam logic [7:0] RST_IRQ_EN     = 8'h00;
  localparam logic [7:0] RST_IN_LOW     = 8'h00;
  localparam logic [7:0] RST_IN_HIGH    = 8'h03;
  localparam logic [7:0] RST_HF_DIV     = 8'h00;
  localparam logic [7:0] RST_GLOBAL     = 8'h00;

  localparam int SONET_BIT = 2;

  localparam logic [3:0] FREQ_8K     = 4'h0;
  localparam logic [3:0] FREQ_T1E1   = 4'h1;
  localparam logic [3:0] FREQ_6M48   = 4'h2;
  localparam logic [3:0] FREQ_19M44  = 4'h3;
  localparam logic [3:0] FREQ_25M92  = 4'h4;
  localparam logic [3:0] FREQ_38M88  = 4'h5;
  localparam logic [3:0] FREQ_2K     = 4'h9;
  localparam logic [3:0] FREQ_4K     = 4'hA;

  typedef enum logic [3:0] {
    RATE_8K = 4'h0, RATE_1M544 = 4'h1, RATE_2M048 = 4'h2, RATE_6M48 = 4'h3,
    RATE_19M44 = 4'h4, RATE_25M92 = 4'h5, RATE_38M88 = 4'h6, RATE_2K = 4'h7,
    RATE_4K = 4'h8, RATE_BAD = 4'hF
  } rate_t;

  typedef enum logic [1:0] {
    PREDIV_BYPASS = 2'b00, PREDIV_LOCK8K = 2'b01, PREDIV_PROGRAMMABLE_N_DIVIDER = 2'b10, PREDIV_BAD = 2'b11
  } prediv_t;

  typedef enum logic [1:0] {
    FDIV_BYPASS = 2'b00, FDIV_BY4 = 2'b01, FDIV_BY5 = 2'b10, FDIV_BAD = 2'b11
  } fast_div_t;

  typedef struct packed {
    logic       external_frame_alarm;
    logic       second_path_lock_change;
    logic       second_path_no_qualified;
    logic       bipolar_violation_input_two;
    logic       signal_loss_input_two;
    logic       bipolar_violation_input_one;
    logic       signal_loss_input_one;
  } events_t;

  typedef struct packed {
    rate_t      rate;
    logic [1:0] bucket_group;
    prediv_t    prediv;
  } input_cfg_t;
endpackage

// >>> input_clock_config.sv
// register bank for interrupt enable 3 and input clock configuration
// assumes wishbone classic master, events are one-cycle pulses on clk_i
//
// Function
// [RULE1] external sync alarm reaches irq only with enable bit 7, reset off
// [RULE2] second path lock change reaches irq only with enable bit 6
// [RULE3] no qualified second-path inputs reaches irq with bit 4; bit 5 reserved
// [RULE4] bipolar violations on inputs 2 and 1 gated by bits 3 and 1
// [RULE5] signal loss on input 2 gated by enable bit 2
// [RULE6] signal loss on input 1 gated by enable bit 0; enables reset off
// [RULE7] inputs 1,2 bit 6 selects 64k+8k (0, default) or 64k+8k+0.4k
// [RULE8] bits 5-4 pick one of four leaky bucket groups, group 0 default
// [RULE9] inputs 1,2 frequency code only 0000, meaning 8 kHz
// [RULE10] inputs 3-6 frequency code decode, other codes reserved
// [RULE11] code 0001 is 1.544 MHz with sonet select, else 2.048 MHz
// [RULE12] bits 7,6 choose bypass, frame_rate_lock_select, N divider or reserved
// [RULE13] fast divider fields for inputs 6 and 5: bypass, /4, /5, reserved
// [RULE14] frequency resets to 8 kHz on inputs 1-4, 19.44 MHz on 5,6
// [RULE15] status flags set on event, clear on write of one
// [RULE16] reserved bits read zero and ignore writes
// [RULE17] irq is or of flags whose enable is set
//
// Register access over Wishbone was chosen for this implementation.
module input_clock_config (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [7:0]             wb_dat_i,
  input  wire logic                   wb_sel_i,
  output logic      [7:0]             wb_dat_o,
  output logic                        wb_ack_o,
  input  wire clk_cfg_pkg::events_t   events_i,
  output logic                        irq_o,
  output clk_cfg_pkg::input_cfg_t     input3_o,
  output clk_cfg_pkg::input_cfg_t     input4_o,
  output clk_cfg_pkg::input_cfg_t     input5_o,
  output clk_cfg_pkg::input_cfg_t     input6_o,
  output clk_cfg_pkg::input_cfg_t     input7_o,
  output logic      [1:0]             input1_bucket_o,
  output logic      [1:0]             input2_bucket_o,
  output logic                        input1_composite_o,
  output logic                        input2_composite_o,
  output clk_cfg_pkg::fast_div_t      fast_divider_input_five_o,
  output clk_cfg_pkg::fast_div_t      fast_divider_input_six_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic clk_cfg_pkg::rate_t decode_rate(input logic [3:0] code,
                                                     input logic       sonet);
    clk_cfg_pkg::rate_t r;
    r = clk_cfg_pkg::RATE_BAD;
    unique case (code)
      clk_cfg_pkg::FREQ_8K:    r = clk_cfg_pkg::RATE_8K;             // [RULE10]
      clk_cfg_pkg::FREQ_T1E1:  r = sonet ? clk_cfg_pkg::RATE_1M544
                                         : clk_cfg_pkg::RATE_2M048;  // [RULE11]
      clk_cfg_pkg::FREQ_6M48:  r = clk_cfg_pkg::RATE_6M48;
      clk_cfg_pkg::FREQ_19M44: r = clk_cfg_pkg::RATE_19M44;
      clk_cfg_pkg::FREQ_25M92: r = clk_cfg_pkg::RATE_25M92;
      clk_cfg_pkg::FREQ_38M88: r = clk_cfg_pkg::RATE_38M88;
      clk_cfg_pkg::FREQ_2K:    r = clk_cfg_pkg::RATE_2K;
      clk_cfg_pkg::FREQ_4K:    r = clk_cfg_pkg::RATE_4K;
      default:                 r = clk_cfg_pkg::RATE_BAD;            // [RULE10]
    endcase
    return r;
  endfunction

  function automatic clk_cfg_pkg::input_cfg_t decode_cfg(input logic [7:0] reg_v,
                                                         input logic       sonet);
    clk_cfg_pkg::input_cfg_t c;
    c.rate         = decode_rate(reg_v[3:0], sonet);
    c.bucket_group = reg_v[5:4];                                      // [RULE8]
    c.prediv       = clk_cfg_pkg::prediv_t'(reg_v[7:6]);              // [RULE12]
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] irq_en_r;
  logic [7:0] status_r;
  logic [7:0] in1_r;
  logic [7:0] in2_r;
  logic [7:0] in3_r;
  logic [7:0] in4_r;
  logic [7:0] hf_div_r;
  logic [7:0] in5_r;
  logic [7:0] in6_r;
  logic [7:0] in7_r;
  logic [7:0] global_r;
  logic [7:0] event_bits;
  logic [7:0] rd_nxt;
  logic       wr_stb;
  logic       access;

  assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_stb = access && wb_we_i && wb_sel_i;

  // event vector laid out like the status register, bit 5 left empty
  assign event_bits = {events_i.external_frame_alarm, events_i.second_path_lock_change,
                       1'b0, events_i.second_path_no_qualified,
                       events_i.bipolar_violation_input_two, events_i.signal_loss_input_two,
                       events_i.bipolar_violation_input_one, events_i.signal_loss_input_one};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en_r <= clk_cfg_pkg::RST_IRQ_EN;                            // [RULE6]
    end else if (wr_stb && wb_adr_i == clk_cfg_pkg::ADDR_IRQ_EN3) begin
      irq_en_r <= wb_dat_i & clk_cfg_pkg::IRQ_EN_MASK;                // [RULE3] [RULE16]
    end
  end

  // a new event in the clear cycle wins, so nothing is lost
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_r <= 8'h00;
    end else begin
      status_r <= ((status_r & ~((wr_stb && wb_adr_i == clk_cfg_pkg::ADDR_STATUS3)
                   ? wb_dat_i : 8'h00)) | event_bits) & clk_cfg_pkg::STATUS_MASK; // [RULE15]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in1_r <= clk_cfg_pkg::RST_IN_LOW;                               // [RULE14]
      in2_r <= clk_cfg_pkg::RST_IN_LOW;
    end else if (wr_stb) begin
      // frequency field held at 8 kHz, the only legal code
      if (wb_adr_i == clk_cfg_pkg::ADDR_IN1) begin
        in1_r <= wb_dat_i & clk_cfg_pkg::IN12_MASK & 8'h70;           // [RULE7] [RULE9]
      end
      if (wb_adr_i == clk_cfg_pkg::ADDR_IN2) begin
        in2_r <= wb_dat_i & clk_cfg_pkg::IN12_MASK & 8'h70;           // [RULE7] [RULE9]
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in3_r <= clk_cfg_pkg::RST_IN_LOW;                               // [RULE14]
      in4_r <= clk_cfg_pkg::RST_IN_LOW;
      in5_r <= clk_cfg_pkg::RST_IN_HIGH;
      in6_r <= clk_cfg_pkg::RST_IN_HIGH;
      in7_r <= clk_cfg_pkg::RST_IN_HIGH;
    end else if (wr_stb) begin
      if (wb_adr_i == clk_cfg_pkg::ADDR_IN3) in3_r <= wb_dat_i;
      if (wb_adr_i == clk_cfg_pkg::ADDR_IN4) in4_r <= wb_dat_i;
      if (wb_adr_i == clk_cfg_pkg::ADDR_IN5) in5_r <= wb_dat_i;
      if (wb_adr_i == clk_cfg_pkg::ADDR_IN6) in6_r <= wb_dat_i;
      if (wb_adr_i == clk_cfg_pkg::ADDR_IN7) in7_r <= wb_dat_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hf_div_r <= clk_cfg_pkg::RST_HF_DIV;
    end else if (wr_stb && wb_adr_i == clk_cfg_pkg::ADDR_HF_DIV) begin
      hf_div_r <= wb_dat_i & clk_cfg_pkg::HF_DIV_MASK;                // [RULE13] [RULE16]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      global_r <= clk_cfg_pkg::RST_GLOBAL;
    end else if (wr_stb && wb_adr_i == clk_cfg_pkg::ADDR_GLOBAL) begin
      global_r <= wb_dat_i & clk_cfg_pkg::GLOBAL_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus answer: one wait state, unmapped reads return zero

  always_comb begin
    rd_nxt = 8'h00;
    unique case (wb_adr_i)
      clk_cfg_pkg::ADDR_STATUS3: rd_nxt = status_r;
      clk_cfg_pkg::ADDR_IRQ_EN3: rd_nxt = irq_en_r;
      clk_cfg_pkg::ADDR_IN1:     rd_nxt = in1_r;
      clk_cfg_pkg::ADDR_IN2:     rd_nxt = in2_r;
      clk_cfg_pkg::ADDR_IN3:     rd_nxt = in3_r;
      clk_cfg_pkg::ADDR_IN4:     rd_nxt = in4_r;
      clk_cfg_pkg::ADDR_HF_DIV:  rd_nxt = hf_div_r;
      clk_cfg_pkg::ADDR_IN5:     rd_nxt = in5_r;
      clk_cfg_pkg::ADDR_IN6:     rd_nxt = in6_r;
      clk_cfg_pkg::ADDR_IN7:     rd_nxt = in7_r;
      clk_cfg_pkg::ADDR_GLOBAL:  rd_nxt = global_r;
      default:                   rd_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 8'h00;
    end else begin
      wb_ack_o <= access;
      wb_dat_o <= access ? rd_nxt : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt and decoded outputs

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      // gating per bit 7,6,4,3,2,1,0 follows the shared layout
      irq_o <= |(status_r & irq_en_r);     // [RULE1] [RULE2] [RULE3] [RULE4] [RULE5] [RULE6] [RULE17]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      input3_o                  <= '0;
      input4_o                  <= '0;
      input5_o                  <= '0;
      input6_o                  <= '0;
      input7_o                  <= '0;
      input1_bucket_o           <= 2'h0;
      input2_bucket_o           <= 2'h0;
      input1_composite_o        <= 1'b0;
      input2_composite_o        <= 1'b0;
      fast_divider_input_five_o <= clk_cfg_pkg::FDIV_BYPASS;
      fast_divider_input_six_o  <= clk_cfg_pkg::FDIV_BYPASS;
    end else begin
      input3_o                  <= decode_cfg(in3_r, global_r[clk_cfg_pkg::SONET_BIT]);
      input4_o                  <= decode_cfg(in4_r, global_r[clk_cfg_pkg::SONET_BIT]);
      input5_o                  <= decode_cfg(in5_r, global_r[clk_cfg_pkg::SONET_BIT]);
      input6_o                  <= decode_cfg(in6_r, global_r[clk_cfg_pkg::SONET_BIT]);
      input7_o                  <= decode_cfg(in7_r, global_r[clk_cfg_pkg::SONET_BIT]);
      input1_bucket_o           <= in1_r[5:4];                        // [RULE8]
      input2_bucket_o           <= in2_r[5:4];
      input1_composite_o        <= in1_r[6];                          // [RULE7]
      input2_composite_o        <= in2_r[6];
      fast_divider_input_five_o <= clk_cfg_pkg::fast_div_t'(hf_div_r[1:0]); // [RULE13]
      fast_divider_input_six_o  <= clk_cfg_pkg::fast_div_t'(hf_div_r[7:6]);
    end
  end

endmodule // input_clock_config

// >>> input_clock_config_properties.sv
// port assertions for the input clock configuration bank
// assumes one clock domain and a bind onto input_clock_config
module input_clock_config_properties (
  input wire logic                     clk_i,
  input wire logic                     rst_i,
  input wire logic                     wb_cyc_i,
  input wire logic                     wb_stb_i,
  input wire logic                     wb_we_i,
  input wire logic [7:0]               wb_adr_i,
  input wire logic [7:0]               wb_dat_o,
  input wire logic                     wb_ack_o,
  input wire clk_cfg_pkg::events_t     events_i,
  input wire logic                     irq_o,
  input wire clk_cfg_pkg::input_cfg_t  input3_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic wr;
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & !wb_ack_o;
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_ack_next_edge: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("stray ack");
  a_data_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 8'h00) else $error("data idle");
  a_unmapped_zero: assert property (wb_ack_o && $past(wb_adr_i) > 8'h1B |-> wb_dat_o == 8'h00)
    else $error("unmapped read");
  a_irq_rise_cause: assert property ($rose(irq_o) |-> $past(|events_i, 2) || $past(|events_i)
    || $past(wr) || $past(wr, 2) || $past(wr, 3)) else $error("irq rise");
  a_irq_fall_cause: assert property ($fell(irq_o) |-> $past(wr) || $past(wr, 2) || $past(wr, 3))
    else $error("irq fall");
  a_cfg_only_write: assert property ($changed(input3_o) |-> $past(wr) || $past(wr, 2)
    || $past(rst_i) || $past(rst_i, 2)) else $error("config drift");
endmodule // input_clock_config_properties

bind input_clock_config input_clock_config_properties i_chk (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .events_i, .irq_o, .input3_o);

// >>> event_source.sv
// stand-in for the alarm and line monitors that raise events
// assumes the bench asks for events as one-cycle strobes on clk_i
module event_source (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [6:0]       fire_i,
  output clk_cfg_pkg::events_t  events_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // registered so each event is a clean single-cycle pulse
  always_ff @(posedge clk_i) begin
    events_o <= rst_i ? '0 : clk_cfg_pkg::events_t'(fire_i);
  end
endmodule // event_source

// >>> input_clock_config_tb.sv
// self-checking bench for the input clock configuration bank
// assumes a wishbone classic slave that acks one access at a time
module input_clock_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
  logic clk_i = 1'b0, rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_sel_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00, wb_dat_i = 8'h00, wb_dat_o, rd, d;
  logic wb_ack_o, irq_o, cc1, cc2;
  logic [6:0] fire = 7'h00;
  logic [1:0] bk1, bk2;
  clk_cfg_pkg::events_t ev;
  clk_cfg_pkg::input_cfg_t input3_o, in4o, in5o, in6o, in7o;
  clk_cfg_pkg::fast_div_t fd5, fd6;
  int num_errors = 0, checks_done = 0;
  logic [7:0] ra [9] = '{8'h12, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B};
  logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h03, 8'h03};
  // reserved bits and the fixed input 1/2 frequency code read back zero
  logic [7:0] rm [9] = '{8'hDF, 8'h70, 8'h70, 8'hFF, 8'hFF, 8'hC3, 8'hFF, 8'hFF, 8'hFF};
  always #5 clk_i = ~clk_i;
  event_source i_event_source (.clk_i, .rst_i, .fire_i(fire), .events_o(ev));
  input_clock_config i_input_clock_config (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .events_i(ev), .irq_o, .input3_o,
    .input4_o(in4o), .input5_o(in5o), .input6_o(in6o), .input7_o(in7o),
    .input1_bucket_o(bk1), .input2_bucket_o(bk2), .input1_composite_o(cc1),
    .input2_composite_o(cc2),
    .fast_divider_input_five_o(fd5), .fast_divider_input_six_o(fd6));
  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] wd);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 1'b1;
    wb_adr_i <= a;
    wb_dat_i <= wd;
    // look just after the edge so the registered ack has settled
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      end_sim();
    end
    rd = wb_dat_o;
    // hold the request up to the edge at which ack is sampled high
    @(posedge clk_i);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic pulse(input logic [6:0] m);
    fire <= m;
    @(posedge clk_i);
    fire <= 7'h00;
    repeat (5) @(posedge clk_i);
  endtask
  function automatic clk_cfg_pkg::rate_t exp_rate(input logic [3:0] c, input logic s);
    case (c)
      4'h0: return clk_cfg_pkg::RATE_8K;
      4'h1: return s ? clk_cfg_pkg::RATE_1M544 : clk_cfg_pkg::RATE_2M048;
      4'h2: return clk_cfg_pkg::RATE_6M48;
      4'h3: return clk_cfg_pkg::RATE_19M44;
      4'h4: return clk_cfg_pkg::RATE_25M92;
      4'h5: return clk_cfg_pkg::RATE_38M88;
      4'h9: return clk_cfg_pkg::RATE_2K;
      4'hA: return clk_cfg_pkg::RATE_4K;
      default: return clk_cfg_pkg::RATE_BAD;
    endcase
  endfunction
  initial begin
    rd = 8'($urandom(32'hF47A));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (ra[i]) begin
      bus(1'b0, ra[i], 8'h00);
      `CHK(rd, rv[i])
    end
    `CHK(in4o.rate, clk_cfg_pkg::RATE_8K)
    `CHK(in5o.rate, clk_cfg_pkg::RATE_19M44)
    `CHK(in6o.rate, clk_cfg_pkg::RATE_19M44)
    repeat (3) foreach (ra[i]) begin
      d = 8'($urandom);
      bus(1'b1, ra[i], d);
      bus(1'b0, ra[i], 8'h00);
      `CHK(rd, d & rm[i])
    end
    bus(1'b1, 8'h13, 8'hFF);
    bus(1'b0, 8'h13, 8'h00);
    `CHK(rd, 8'h00)
    for (int s = 0; s < 2; s++) begin
      bus(1'b1, 8'h09, s[0] ? 8'h04 : 8'h00);
      for (logic [4:0] c = 0; c < 16; c++) begin
        d = {c[1:0], c[3:2], c[3:0]};
        bus(1'b1, 8'h16, d);
        `CHK(input3_o.rate, exp_rate(c[3:0], s[0]))
        `CHK(input3_o.bucket_group, d[5:4])
        `CHK(input3_o.prediv, d[7:6])
        bus(1'b1, 8'h17, d);
        bus(1'b1, 8'h19, d);
        bus(1'b1, 8'h1A, d);
        bus(1'b1, 8'h1B, d);
        `CHK(in4o.rate, exp_rate(c[3:0], s[0]))
        `CHK(in5o.rate, exp_rate(c[3:0], s[0]))
        `CHK(in6o.bucket_group, d[5:4])
        `CHK(in7o.prediv, d[7:6])
      end
    end
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 8'h18, {k[1:0], 4'hF, 2'(3 - k)});
      `CHK(fd6, clk_cfg_pkg::fast_div_t'(k))
      `CHK(fd5, clk_cfg_pkg::fast_div_t'(3 - k))
      bus(1'b1, 8'h14, {1'b0, k[0], k[1:0], 4'h0});
      `CHK({cc1, bk1}, {k[0], k[1:0]})
      bus(1'b1, 8'h15, {1'b1, ~k[0], ~k[1:0], 4'hF});
      `CHK({cc2, bk2}, {~k[0], ~k[1:0]})
    end
    // each event alone: reported when enabled, silent when only the others are
    for (int i = 0; i < 7; i++) begin
      d = 8'h01 << (i > 4 ? i + 1 : i);
      bus(1'b1, 8'h12, d);
      pulse(7'h01 << i);
      `CHK(irq_o, 1'b1)
      bus(1'b0, 8'h0F, 8'h00);
      `CHK(rd, d)
      bus(1'b1, 8'h0F, d);
      `CHK(irq_o, 1'b0)
      bus(1'b1, 8'h12, ~d);
      pulse(7'h01 << i);
      `CHK(irq_o, 1'b0)
      bus(1'b1, 8'h0F, 8'hFF);
    end
    end_sim();
  end
endmodule // input_clock_config_tb
